// file: src/clpc_top.sv
// Clock selection, clock supervision and low-power sequencing controller.
// Assumes oscillator ready and failure detectors are synchronous levels.
//
// Functional notes
// - Reset runs core from fast RC.
// - Software selects external or multiplied clock.
// - Multiplied clock doubles its chosen source.
// - Safe mode falls back to RC.
// - Wake from stopped clocks selects RC.
// - Clock failure event raises interrupt.
// - Monitor failure brakes timer, sets flag.
// - Enabled monitor interrupt is taken.
// - Sleep gates only the core clock.
// - Any interrupt or event ends sleep.
// - Standby stops fast oscillators, keeps state.
// - Regulator low-power in standby, else on.
// - Standby wake continues on fast RC.
// - Event lines, reset pin, watchdog end standby.
// - Held in reset while supply low.
// - Voltage monitor off until enabled; edge interrupts.
`timescale 1ns/1ns
module clpc_top #(
    parameter int EVENT_LINES = 31,
    parameter int SETTLE = clpc_pkg::SETTLE_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_en,
    input wire logic [clpc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic power_on_down_reset_n,
    input wire logic reset_pin_n,
    input wire logic independent_watchdog_reset,
    input wire logic [EVENT_LINES-1:0] external_event_lines,
    input wire logic any_interrupt,
    input wire logic wake_event,
    input wire logic deep_sleep_indication,
    input wire logic wait_request,
    input wire logic internal_fast_rc_ready,
    input wire logic external_oscillator_ready,
    input wire logic multiplier_ready,
    input wire logic external_oscillator_fail,
    input wire logic system_clock_fail,
    input wire logic supply_below_threshold,
    output logic internal_fast_rc_on,
    output logic external_oscillator_on,
    output logic multiplier_on,
    output logic multiplier_from_ext,
    output logic [1:0] system_clock_sel,
    output logic core_clock_en,
    output logic peripheral_clock_en,
    output logic regulator_low_power,
    output logic advanced_timer_brake,
    output logic system_reset_n,
    output logic irq
);
    typedef struct packed {
        // Software-visible registers.
        logic [7:0] clk_ctrl;
        logic [3:0] pwr_ctrl;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        // Sequencer state.
        clpc_pkg::clpc_src_t cur_src;
        clpc_pkg::clpc_pwr_t pwr;
        logic [15:0] settle;
        logic vmon_prev;
        logic [31:0] rdata;
        // Registered outputs.
        logic rc_on;
        logic ext_on;
        logic mul_on;
        logic brake;
        logic irq;
        logic core_en;
        logic periph_en;
        logic reg_lp;
    } clpc_state_t;

    // Unmapped indices read as zero so software can probe the map safely.
    function automatic logic [31:0] read_word(
        input logic [clpc_pkg::ADDR_W-1:0] a,
        input clpc_state_t s
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            clpc_pkg::ADDR_CLOCK_CTRL: begin
                w = {24'h0, s.clk_ctrl};
            end
            clpc_pkg::ADDR_CLOCK_STATUS: begin
                w = {24'h0, s.mul_on, s.ext_on, s.rc_on,
                    s.brake, s.pwr, s.cur_src};
            end
            clpc_pkg::ADDR_POWER_CTRL: begin
                w = {28'h0, s.pwr_ctrl};
            end
            clpc_pkg::ADDR_IRQ_STATUS: begin
                w = {29'h0, s.irq_stat};
            end
            clpc_pkg::ADDR_IRQ_MASK: begin
                w = {29'h0, s.irq_mask};
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    // Code 3 is reserved and falls back to the RC oscillator.
    function automatic clpc_pkg::clpc_src_t decode_sel(input logic [1:0] c);
        clpc_pkg::clpc_src_t r;
        case (c)
            2'b01: begin
                r = clpc_pkg::CLPC_SRC_EXT;
            end
            2'b10: begin
                r = clpc_pkg::CLPC_SRC_MUL;
            end
            default: begin
                r = clpc_pkg::CLPC_SRC_RC;
            end
        endcase
        return r;
    endfunction

    // Dropping the requests keeps the switch logic from re-arming them.
    function automatic logic [7:0] drop_requests(input logic [7:0] c);
        logic [7:0] r;
        r = c;
        r[1:0] = 2'b00;
        r[clpc_pkg::EXT_ON_POS] = 1'b0;
        r[clpc_pkg::MUL_ON_POS] = 1'b0;
        return r;
    endfunction

    clpc_state_t st;
    clpc_state_t next_st;
    logic sys_rst_n;
    // The release is synchronised; assertion stays asynchronous.
    logic [1:0] rst_sync;

    // A source counts as running only once its ready level is high.
    function automatic logic src_ready(input clpc_pkg::clpc_src_t s,
                                       input logic rc, input logic ex,
                                       input logic mu);
        case (s)
            clpc_pkg::CLPC_SRC_EXT: src_ready = ex;
            clpc_pkg::CLPC_SRC_MUL: src_ready = mu;
            default: src_ready = rc;
        endcase
    endfunction

    // Supply and pin resets are combined before the release synchroniser.
    logic raw_rst_n;
    assign raw_rst_n = rst_n & power_on_down_reset_n & reset_pin_n
        & ~independent_watchdog_reset;
    assign sys_rst_n = rst_sync[1];

    always_ff @(posedge clock or negedge raw_rst_n) begin
        if (!raw_rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    always_comb begin
        logic [2:0] events;
        logic [2:0] wclr;
        logic on_ext;
        clpc_pkg::clpc_src_t want;
        events = 3'h0;
        wclr = 3'h0;
        on_ext = 1'b0;
        want = clpc_pkg::CLPC_SRC_RC;
        next_st = st;
        next_st.rdata = 32'h0000_0000;

        if (reg_write) begin
            case (reg_addr)
                clpc_pkg::ADDR_CLOCK_CTRL: begin
                    next_st.clk_ctrl = reg_wdata[7:0];
                end
                clpc_pkg::ADDR_POWER_CTRL: begin
                    next_st.pwr_ctrl = reg_wdata[3:0];
                end
                clpc_pkg::ADDR_IRQ_STATUS: begin
                    wclr = reg_wdata[2:0];
                end
                clpc_pkg::ADDR_IRQ_MASK: begin
                    next_st.irq_mask = reg_wdata[2:0];
                end
                default: begin
                end
            endcase
        end
        if (reg_read) begin
            next_st.rdata = read_word(reg_addr, st);
        end

        // The multiplier doubles either RC or external, per this bit.
        on_ext = (st.cur_src == clpc_pkg::CLPC_SRC_EXT)
            || (st.cur_src == clpc_pkg::CLPC_SRC_MUL
                && st.clk_ctrl[clpc_pkg::MUL_SRC_POS]);

        if (next_st.clk_ctrl[clpc_pkg::SAFE_EN_POS] && on_ext
                && external_oscillator_fail) begin
            // Fallback also drops the request so it cannot re-arm.
            next_st.clk_ctrl = drop_requests(next_st.clk_ctrl);
            next_st.cur_src = clpc_pkg::CLPC_SRC_RC;
            events[clpc_pkg::IRQ_EXT_FAIL] = 1'b1;
        end

        if (st.clk_ctrl[clpc_pkg::MON_EN_POS] && system_clock_fail) begin
            events[clpc_pkg::IRQ_SYS_FAIL] = 1'b1;
        end
        next_st.brake = st.clk_ctrl[clpc_pkg::MON_EN_POS]
            && system_clock_fail;

        next_st.vmon_prev = supply_below_threshold;
        if (st.pwr_ctrl[clpc_pkg::VMON_EN_POS]) begin
            if ((supply_below_threshold && !st.vmon_prev
                    && st.pwr_ctrl[clpc_pkg::VMON_FALL_POS])
                    || (!supply_below_threshold && st.vmon_prev
                    && st.pwr_ctrl[clpc_pkg::VMON_RISE_POS])) begin
                events[clpc_pkg::IRQ_VMON] = 1'b1;
            end
        end

        // A set arriving with its clear keeps the flag.
        next_st.irq_stat = (st.irq_stat & ~wclr) | events;

        // Standby wins when both low-power requests come together.
        case (st.pwr)
            clpc_pkg::CLPC_RUN: begin
                if (deep_sleep_indication
                        && st.pwr_ctrl[clpc_pkg::DEEP_EN_POS]) begin
                    next_st.pwr = clpc_pkg::CLPC_STANDBY;
                end else if (wait_request) begin
                    next_st.pwr = clpc_pkg::CLPC_SLEEP;
                end
            end
            clpc_pkg::CLPC_SLEEP: begin
                if (any_interrupt || wake_event || |st.irq) begin
                    next_st.pwr = clpc_pkg::CLPC_RUN;
                end
            end
            clpc_pkg::CLPC_STANDBY: begin
                if (|external_event_lines) begin
                    // Resets leave standby through the reset path.
                    next_st.pwr = clpc_pkg::CLPC_RUN;
                    next_st.clk_ctrl = drop_requests(next_st.clk_ctrl);
                    next_st.cur_src = clpc_pkg::CLPC_SRC_RC;
                end
            end
            default: next_st.pwr = clpc_pkg::CLPC_RUN;
        endcase

        // Oscillators stop in standby; configuration is retained.
        next_st.rc_on = (next_st.pwr != clpc_pkg::CLPC_STANDBY);
        next_st.ext_on = next_st.rc_on
            && next_st.clk_ctrl[clpc_pkg::EXT_ON_POS];
        next_st.mul_on = next_st.rc_on
            && next_st.clk_ctrl[clpc_pkg::MUL_ON_POS];
        // Enables are registered so the clock gates see no decode glitch.
        next_st.core_en = (next_st.pwr == clpc_pkg::CLPC_RUN);
        next_st.periph_en = (next_st.pwr != clpc_pkg::CLPC_STANDBY);
        next_st.reg_lp = (next_st.pwr == clpc_pkg::CLPC_STANDBY);

        // Switch only after the target has been ready for the settle time.
        // The settle count restarts whenever the target drops its ready.
        want = decode_sel(next_st.clk_ctrl[1:0]);
        if (want == next_st.cur_src || !src_ready(want,
                internal_fast_rc_ready, external_oscillator_ready,
                multiplier_ready)) begin
            next_st.settle = 16'h0000;
        end else if (st.settle >= 16'(SETTLE - 1)) begin
            next_st.cur_src = want;
            next_st.settle = 16'h0000;
        end else begin
            next_st.settle = st.settle + 16'h0001;
        end

        // A mask change shows on the output one cycle after its write.
        next_st.irq = |(next_st.irq_stat & st.irq_mask);
    end

    always_ff @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            st.clk_ctrl <= clpc_pkg::CLOCK_CTRL_RESET;
            st.pwr_ctrl <= clpc_pkg::POWER_CTRL_RESET;
            st.irq_stat <= 3'h0;
            st.irq_mask <= clpc_pkg::IRQ_MASK_RESET;
            st.cur_src <= clpc_pkg::CLPC_SRC_RC;
            st.pwr <= clpc_pkg::CLPC_RUN;
            st.settle <= 16'h0000;
            st.vmon_prev <= 1'b0;
            st.rdata <= 32'h0000_0000;
            st.rc_on <= 1'b1;
            st.ext_on <= 1'b0;
            st.mul_on <= 1'b0;
            st.brake <= 1'b0;
            st.irq <= 1'b0;
            st.core_en <= 1'b1;
            st.periph_en <= 1'b1;
            st.reg_lp <= 1'b0;
        end else if (clock_en) begin
            // Clock enable low holds every flop but the reset release.
            st.clk_ctrl <= next_st.clk_ctrl;
            st.pwr_ctrl <= next_st.pwr_ctrl;
            st.irq_stat <= next_st.irq_stat;
            st.irq_mask <= next_st.irq_mask;
            st.cur_src <= next_st.cur_src;
            st.pwr <= next_st.pwr;
            st.settle <= next_st.settle;
            st.vmon_prev <= next_st.vmon_prev;
            st.rdata <= next_st.rdata;
            st.rc_on <= next_st.rc_on;
            st.ext_on <= next_st.ext_on;
            st.mul_on <= next_st.mul_on;
            st.brake <= next_st.brake;
            st.irq <= next_st.irq;
            st.core_en <= next_st.core_en;
            st.periph_en <= next_st.periph_en;
            st.reg_lp <= next_st.reg_lp;
        end
    end

    assign reg_rdata = st.rdata;
    assign internal_fast_rc_on = st.rc_on;
    assign external_oscillator_on = st.ext_on;
    assign multiplier_on = st.mul_on;
    assign multiplier_from_ext = st.clk_ctrl[clpc_pkg::MUL_SRC_POS];
    assign system_clock_sel = st.cur_src;
    // Every output below is a plain flop or a flop bit.
    assign core_clock_en = st.core_en;
    assign peripheral_clock_en = st.periph_en;
    assign regulator_low_power = st.reg_lp;
    assign advanced_timer_brake = st.brake;
    assign system_reset_n = sys_rst_n;
    assign irq = st.irq;
endmodule

// file: include/clpc_pkg.sv
// Constants, types and register map of the clock and low-power controller.
// Assumes a single 50 MHz clock and a plain strobe register port.
package clpc_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_CLOCK_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CLOCK_STATUS = 4'h1;
    localparam logic [3:0] ADDR_POWER_CTRL = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    // Clock control fields.
    localparam int SEL_LSB = 0;
    localparam int MUL_SRC_POS = 2;
    localparam int EXT_ON_POS = 3;
    localparam int MUL_ON_POS = 4;
    localparam int SAFE_EN_POS = 5;
    localparam int MON_EN_POS = 6;
    // Power control fields.
    localparam int DEEP_EN_POS = 0;
    localparam int VMON_EN_POS = 1;
    localparam int VMON_FALL_POS = 2;
    localparam int VMON_RISE_POS = 3;
    // Interrupt status fields.
    localparam int IRQ_EXT_FAIL = 0;
    localparam int IRQ_SYS_FAIL = 1;
    localparam int IRQ_VMON = 2;
    localparam int IRQ_W = 3;
    localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
    localparam logic [3:0] POWER_CTRL_RESET = 4'h0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    // Clock figures.
    localparam int CLOCK_HZ = 50000000;
    localparam int RC_FAST_MHZ = 24;
    localparam int MUL_FACTOR = 2;
    // Settling time of a source before a switch completes.
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYCLES = (SETTLE_NS * (CLOCK_HZ / 1000000) + 999)
        / 1000;
    typedef enum logic [1:0] {
        CLPC_SRC_RC = 2'b00,
        CLPC_SRC_EXT = 2'b01,
        CLPC_SRC_MUL = 2'b10
    } clpc_src_t;
    typedef enum logic [1:0] {
        CLPC_RUN = 2'b00,
        CLPC_SLEEP = 2'b01,
        CLPC_STANDBY = 2'b10
    } clpc_pwr_t;
endpackage

// file: bench/clpc_top_asserts.sv
// Port-level checks for the clock and low-power controller.
// Bound into every clpc_top; sees only its ports.
`timescale 1ns/1ns
module clpc_top_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic any_interrupt,
    input wire logic wake_event,
    input wire logic external_oscillator_ready,
    input wire logic system_clock_fail,
    input wire logic internal_fast_rc_on,
    input wire logic external_oscillator_on,
    input wire logic multiplier_on,
    input wire logic [1:0] system_clock_sel,
    input wire logic core_clock_en,
    input wire logic peripheral_clock_en,
    input wire logic regulator_low_power,
    input wire logic advanced_timer_brake,
    input wire logic system_reset_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_reset_state: assert property (
        !system_reset_n |-> internal_fast_rc_on && system_clock_sel == 2'h0)
        else $error("bad reset state");
    a_sleep_periph: assert property (
        !core_clock_en && !regulator_low_power |-> peripheral_clock_en)
        else $error("peripherals stopped in sleep");
    a_standby_off: assert property (
        $rose(regulator_low_power) |-> ##1 !(internal_fast_rc_on
        || external_oscillator_on || multiplier_on || peripheral_clock_en))
        else $error("clocks left on in standby");
    a_brake_cause: assert property (
        $rose(advanced_timer_brake) |-> $past(system_clock_fail))
        else $error("brake without failure");
    a_ext_ready: assert property (
        $changed(system_clock_sel) && system_clock_sel == 2'h1
        |-> $past(external_oscillator_ready, 2))
        else $error("switch before source ready");
    a_wake_rc: assert property (
        $fell(regulator_low_power) && system_reset_n
        |-> ##[0:2] (system_clock_sel == 2'h0 && internal_fast_rc_on))
        else $error("wake not on fast RC");
    a_sleep_wake: assert property (
        !core_clock_en && !regulator_low_power && system_reset_n
        && (any_interrupt || wake_event) |-> ##[1:2] core_clock_en)
        else $error("sleep not left");
    a_read_idle: assert property (
        system_reset_n && !$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule
bind clpc_top clpc_top_chk i_chk (.*);

// file: bench/clpc_osc_model.sv
// Behavioural model of the clock sources facing the controller.
// The bench raises osc_kill to make the crystal fail.
`timescale 1ns/1ns
module clpc_osc_model #(
    parameter int LAT = 5
) (
    input wire logic clock,
    input wire logic internal_fast_rc_on,
    input wire logic external_oscillator_on,
    input wire logic multiplier_on,
    input wire logic osc_kill,
    output logic internal_fast_rc_ready,
    output logic external_oscillator_ready,
    output logic multiplier_ready,
    output logic external_oscillator_fail
);
    int n_ext = 0;
    // A crystal needs time to build up, so ready lags the enable.
    always @(posedge clock) begin
        n_ext <= external_oscillator_on ? n_ext + 1 : 0;
    end
    assign external_oscillator_ready = n_ext >= LAT && !osc_kill;
    assign external_oscillator_fail = osc_kill && external_oscillator_on;
    assign internal_fast_rc_ready = internal_fast_rc_on;
    assign multiplier_ready = multiplier_on;
endmodule

// file: bench/clock_and_low_power_control_test.sv
// Self-checking bench for the clock and low-power controller.
// Outputs are read at the edge, so they show last cycle's values.
`timescale 1ns/1ns
module clock_and_low_power_control_test;
    logic clock = 1'b0, rst_n = 1'b0, clock_en = 1'b1;
    logic reg_write = 1'b0, reg_read = 1'b0, osc_kill = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [2:0] rv [3] = '{3'b010, 3'b001, 3'b111};
    logic power_on_down_reset_n = 1'b1, reset_pin_n = 1'b1;
    logic independent_watchdog_reset = 1'b0, any_interrupt = 1'b0;
    logic [30:0] external_event_lines = 31'h0;
    logic wake_event = 1'b0, deep_sleep_indication = 1'b0;
    logic wait_request = 1'b0, system_clock_fail = 1'b0;
    logic supply_below_threshold = 1'b0, internal_fast_rc_ready;
    logic external_oscillator_ready, multiplier_ready, irq;
    logic external_oscillator_fail, internal_fast_rc_on, multiplier_on;
    logic external_oscillator_on, multiplier_from_ext, core_clock_en;
    logic peripheral_clock_en, regulator_low_power, system_reset_n;
    logic advanced_timer_brake;
    logic [1:0] system_clock_sel;
    int n_mismatch = 0, comparisons = 0;
    wire [8:0] st = {system_reset_n, regulator_low_power, core_clock_en,
        peripheral_clock_en, internal_fast_rc_on, external_oscillator_on,
        multiplier_on, system_clock_sel};
    clpc_top #(.SETTLE(3)) i_dut (.*);
    clpc_osc_model #(.LAT(5)) i_osc (.*);
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        cyc(1);
        reg_write <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        cyc(1);
        reg_read <= 1'b0;
        cyc(1);
        check(reg_rdata, e);
    endtask
    task automatic wsel(input logic [1:0] s);
        repeat (60) if (system_clock_sel !== s) cyc(1);
        check(32'(system_clock_sel), 32'(s));
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        cyc(5000);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        cyc(6);
        rst_n <= 1'b1;
        cyc(3);
        check(32'(st), 32'h170);
        rd(clpc_pkg::ADDR_CLOCK_CTRL, 32'h0);
        rd(4'hF, 32'h0);
        wr(clpc_pkg::ADDR_IRQ_MASK, 32'h5);
        wr(clpc_pkg::ADDR_CLOCK_CTRL, 32'h69);
        wsel(2'h1);
        osc_kill <= 1'b1;
        cyc(4);
        osc_kill <= 1'b0;
        check(32'(st), 32'h170);
        check(32'(irq), 32'h1);
        rd(clpc_pkg::ADDR_IRQ_STATUS, 32'h1);
        wr(clpc_pkg::ADDR_IRQ_STATUS, 32'h1);
        cyc(2);
        check(32'(irq), 32'h0);
        system_clock_fail <= 1'b1;
        cyc(4);
        check(32'({advanced_timer_brake, irq}), 32'h2);
        wr(clpc_pkg::ADDR_IRQ_MASK, 32'h7);
        cyc(2);
        check(32'(irq), 32'h1);
        system_clock_fail <= 1'b0;
        rd(clpc_pkg::ADDR_IRQ_STATUS, 32'h2);
        wr(clpc_pkg::ADDR_IRQ_STATUS, 32'h2);
        wr(clpc_pkg::ADDR_CLOCK_CTRL, 32'h12);
        wsel(2'h2);
        check(32'(st), 32'h176);
        rd(clpc_pkg::ADDR_CLOCK_STATUS, 32'hA2);
        wr(clpc_pkg::ADDR_POWER_CTRL, 32'h1);
        deep_sleep_indication <= 1'b1;
        cyc(4);
        deep_sleep_indication <= 1'b0;
        cyc(4);
        check(32'(st[8:2]), 32'h60);
        external_event_lines <= 31'h4000_0000;
        cyc(4);
        external_event_lines <= 31'h0;
        check(32'(st), 32'h170);
        rd(clpc_pkg::ADDR_POWER_CTRL, 32'h1);
        wr(clpc_pkg::ADDR_POWER_CTRL, 32'h0);
        for (int i = 1; i < 3; i++) begin
            wait_request <= 1'b1;
            cyc(4);
            check(32'(st), 32'h130);
            wait_request <= 1'b0;
            {wake_event, any_interrupt} <= 2'(i);
            cyc(4);
            {wake_event, any_interrupt} <= 2'h0;
            check(32'(st), 32'h170);
        end
        supply_below_threshold <= 1'b1;
        cyc(4);
        supply_below_threshold <= 1'b0;
        rd(clpc_pkg::ADDR_IRQ_STATUS, 32'h0);
        wr(clpc_pkg::ADDR_POWER_CTRL, 32'h6);
        supply_below_threshold <= 1'b1;
        cyc(4);
        check(32'(irq), 32'h1);
        rd(clpc_pkg::ADDR_IRQ_STATUS, 32'h4);
        wr(clpc_pkg::ADDR_CLOCK_CTRL, 32'h4);
        check(32'(multiplier_from_ext), 32'h1);
        for (int i = 0; i < 3; i++) begin
            {independent_watchdog_reset, reset_pin_n, power_on_down_reset_n}
                <= rv[i];
            cyc(2);
            check(32'(st), 32'h070);
            {independent_watchdog_reset, reset_pin_n, power_on_down_reset_n}
                <= 3'b011;
            cyc(4);
            check(32'(st), 32'h170);
        end
        wrap_up();
    end
endmodule
